// file: design/autoneg_map.vh
// register offsets, field positions, reset values and counts of the ability registers
`ifndef AUTONEG_MAP_VH
`define AUTONEG_MAP_VH

// register offsets on the management port
`define ADV_OFFSET 5'h04
`define LPA_OFFSET 5'h05
`define ADDR_W 5
`define DATA_W 16

// local advertisement field positions
`define ADV_10_FULL_BIT 6
`define ADV_10_HALF_BIT 5
`define SEL_MSB 4
`define SEL_LSB 0
`define ADV_UPPER_W 9

// local advertisement reset and fixed values
`define ADV_10_FULL_RST 1'b1
`define ADV_10_HALF_RST 1'b1
`define SEL_CSMA_CD 5'h01

// partner ability field positions
`define LPA_NEXT_PAGE_BIT 15
`define LPA_ACK_BIT 14
`define LPA_REMOTE_FAULT_BIT 13
`define LPA_PAUSE_BIT 10
`define LPA_T4_BIT 9
`define LPA_TX_FULL_BIT 8
`define LPA_TX_HALF_BIT 7
`define LPA_10_FULL_BIT 6
`define LPA_10_HALF_BIT 5

// partner bits that are stored; reserved bits 12 and 11 read as zero
`define LPA_IMPL_MASK 16'he7ff
`define LPA_RST 16'h0000

// identical received words needed before the partner register is loaded
`define MATCH_COUNT 2'h3
`define MATCH_W 2

`endif

// file: design/lcw_match.v
// consistency filter for received link code words
`timescale 1ns/1ps
`include "autoneg_map.vh"

module lcw_match (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // received words from the arbitration logic
    input wire [`DATA_W-1:0] rx_word,
    input wire rx_word_valid,
    input wire an_restart,
    // filtered word
    output reg [`DATA_W-1:0] match_word,
    output reg match_load
);

reg [`DATA_W-1:0] last_word_reg;
reg [`MATCH_W-1:0] match_cnt_reg;
reg [`MATCH_W-1:0] match_cnt_next;
wire same_word;
wire load_now;

assign same_word = (rx_word == last_word_reg);

// third identical word arrives in this cycle
assign load_now = rx_word_valid && (match_cnt_next == `MATCH_COUNT) &&
    (match_cnt_reg != `MATCH_COUNT);

// count consecutive identical words, restarting on a different word
always @* begin
    match_cnt_next = match_cnt_reg;
    if (rx_word_valid) begin
        if (same_word && (match_cnt_reg != 2'h0)) begin
            if (match_cnt_reg != `MATCH_COUNT) begin
                match_cnt_next = match_cnt_reg + 2'h1;
            end
        end else begin
            match_cnt_next = 2'h1;
        end
    end
end

// hold the last word and pulse once when the count is reached
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        last_word_reg <= `LPA_RST;
        match_cnt_reg <= 2'h0;
        match_word <= `LPA_RST;
        match_load <= 1'b0;
    end else begin
        match_load <= 1'b0;
        // restart drops the count unless a load happens in the same cycle
        if (an_restart && !load_now) begin
            match_cnt_reg <= 2'h0;
        end else begin
            match_cnt_reg <= match_cnt_next;
        end
        if (rx_word_valid) begin
            last_word_reg <= rx_word;
        end
        if (load_now) begin
            match_word <= rx_word;
            match_load <= 1'b1;
        end
    end
end

endmodule // lcw_match

// file: design/reg_read_port.v
// registered read-data path of the management port
`timescale 1ns/1ps
`include "autoneg_map.vh"

module reg_read_port (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // read request
    input wire [`ADDR_W-1:0] reg_addr,
    input wire reg_rd,
    // register contents
    input wire [`DATA_W-1:0] adv_value,
    input wire [`DATA_W-1:0] lpa_value,
    // read answer
    output reg [`DATA_W-1:0] reg_rdata
);

reg [`DATA_W-1:0] rdata_next;

// address decode; unmapped addresses read as zero
always @* begin
    rdata_next = 16'h0000;
    case (reg_addr)
        `ADV_OFFSET: begin
            rdata_next = adv_value;
        end
        `LPA_OFFSET: begin
            rdata_next = lpa_value;
        end
        default: begin
            rdata_next = 16'h0000;
        end
    endcase
end

// data stand only in the cycle after the read strobe
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
        reg_rdata <= rdata_next;
    end else begin
        reg_rdata <= 16'h0000;
    end
end

endmodule // reg_read_port

// file: design/autoneg_ability_registers.v
// local advertisement and link-partner ability registers of the auto-negotiation block
//
// Summary of operation
// - bit 6 of register 4 stores and advertises 10BASE-T full duplex
// - bit 5 of register 4 stores and advertises 10BASE-T half duplex
// - both advertise bits read back last written value or their default
// - reset returns both advertise bits to 1
// - advertisement selector bits 4 to 0 are fixed at 00001, CSMA/CD
// - partner register holds received link code word, read-only
// - partner next page bit is copied only, never acted upon
// - register 5 bit 14 shows the partner acknowledge
// - register 5 bit 13 shows partner remote fault, no further action
// - register 5 bit 10 mirrors the partner pause bit
// - register 5 bit 9 partner T4, cleared on reset, and on restart unless a load lands in the same cycle
// - register 5 bits 8 to 5 partner abilities, cleared on reset, and on restart unless a load lands in the same cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "autoneg_map.vh"

module autoneg_ability_registers (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // management register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [`DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [`DATA_W-1:0] reg_rdata,
    // upper advertisement bits held elsewhere
    input wire [`ADV_UPPER_W-1:0] adv_upper,
    // negotiation engine side
    input wire an_restart,
    input wire [`DATA_W-1:0] rx_word,
    input wire rx_word_valid,
    output reg [`DATA_W-1:0] tx_word,
    // partner ability status
    output wire partner_next_page,
    output wire partner_ack,
    output wire partner_remote_fault,
    output wire partner_pause,
    output wire partner_t4,
    output wire partner_tx_full,
    output wire partner_tx_half,
    output wire partner_10_full,
    output wire partner_10_half,
    output reg partner_loaded
);

// local advertisement state
reg adv_10_full_reg;
reg adv_10_full_next;
reg adv_10_half_reg;
reg adv_10_half_next;
wire adv_wr;
wire [`SEL_MSB:`SEL_LSB] adv_selector;
wire [`DATA_W-1:0] adv_value;

// partner ability state
wire [`DATA_W-1:0] lpa_value;
wire [`DATA_W-1:0] match_word;
wire match_load;

// write decode for the advertisement register; register 5 ignores writes
assign adv_wr = reg_wr && (reg_addr == `ADV_OFFSET);

// selector is a constant, writes to it have no effect
assign adv_selector = `SEL_CSMA_CD;

// next values of the two advertise bits
always @* begin
    adv_10_full_next = adv_10_full_reg;
    adv_10_half_next = adv_10_half_reg;
    if (adv_wr) begin
        adv_10_full_next = reg_wdata[`ADV_10_FULL_BIT];
        adv_10_half_next = reg_wdata[`ADV_10_HALF_BIT];
    end
end

// advertise bits, default 1 after reset
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        adv_10_full_reg <= `ADV_10_FULL_RST;
        adv_10_half_reg <= `ADV_10_HALF_RST;
    end else begin
        adv_10_full_reg <= adv_10_full_next;
        adv_10_half_reg <= adv_10_half_next;
    end
end

// full advertisement word as read and as sent
assign adv_value = {adv_upper, adv_10_full_reg, adv_10_half_reg, adv_selector};

// base link code word follows the register bit for bit one cycle later; bits 15 to 7 are zero during reset
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        tx_word <= {9'h000, `ADV_10_FULL_RST, `ADV_10_HALF_RST, `SEL_CSMA_CD};
    end else begin
        tx_word <= adv_value;
    end
end

// filter so that a single corrupted word never reaches the register
lcw_match u_lcw_match (
    .clk(clk),
    .rst_b(rst_b),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .an_restart(an_restart),
    .match_word(match_word),
    .match_load(match_load)
);

// partner register, one flop per stored bit, reserved bits tied low
genvar gi;
generate
    for (gi = 0; gi < `DATA_W; gi = gi + 1) begin : g_lpa
        if (((`LPA_IMPL_MASK >> gi) & 16'h0001) != 16'h0000) begin : g_store
            reg lpa_bit_reg;
            // load wins over a restart in the same cycle
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    lpa_bit_reg <= 1'b0;
                end else if (match_load) begin
                    lpa_bit_reg <= match_word[gi];
                end else if (an_restart) begin
                    lpa_bit_reg <= 1'b0;
                end
            end
            assign lpa_value[gi] = lpa_bit_reg;
        end else begin : g_resv
            assign lpa_value[gi] = 1'b0;
        end
    end
endgenerate

// partner fields to the rest of the chip
assign partner_next_page = lpa_value[`LPA_NEXT_PAGE_BIT];
assign partner_ack = lpa_value[`LPA_ACK_BIT];
assign partner_remote_fault = lpa_value[`LPA_REMOTE_FAULT_BIT];
assign partner_pause = lpa_value[`LPA_PAUSE_BIT];
assign partner_t4 = lpa_value[`LPA_T4_BIT];
assign partner_tx_full = lpa_value[`LPA_TX_FULL_BIT];
assign partner_tx_half = lpa_value[`LPA_TX_HALF_BIT];
assign partner_10_full = lpa_value[`LPA_10_FULL_BIT];
assign partner_10_half = lpa_value[`LPA_10_HALF_BIT];

// one-cycle notice that the partner register was reloaded
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        partner_loaded <= 1'b0;
    end else begin
        partner_loaded <= match_load;
    end
end

// registered read answer
reg_read_port u_reg_read_port (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .adv_value(adv_value),
    .lpa_value(lpa_value),
    .reg_rdata(reg_rdata)
);

endmodule // autoneg_ability_registers

// file: tb/ability_regs_sva.sv
// assertion checker for the ability registers
`timescale 1ns/1ps
module ability_regs_chk (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [8:0] adv_upper,
    // negotiation side
    input wire an_restart,
    input wire [15:0] rx_word,
    input wire rx_word_valid,
    input wire [15:0] tx_word,
    input wire partner_next_page,
    input wire partner_ack,
    input wire partner_remote_fault,
    input wire partner_pause,
    input wire partner_t4,
    input wire partner_tx_full,
    input wire partner_tx_half,
    input wire partner_10_full,
    input wire partner_10_half,
    input wire partner_loaded
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // repeat of the last word, no restart
    sequence same_word;
        rx_word_valid && $stable(rx_word) && !an_restart;
    endsequence
    // three identical words back to back
    sequence three_same;
        rx_word_valid && !an_restart ##1 same_word ##1 same_word;
    endsequence
    // advertisement write with no write after it
    sequence adv_write;
        reg_wr && reg_addr == 5'h04 ##1 !reg_wr;
    endsequence
    sel_fixed_a: assert property (tx_word[4:0] == 5'h01)
        else $error("sent selector wrong");
    adv_sent_a: assert property (adv_write |=> tx_word[6:5] == $past(reg_wdata[6:5], 2))
        else $error("sent advert bits wrong");
    rd_adv_a: assert property (reg_rd && reg_addr == 5'h04 |=>
        reg_rdata[15:7] == $past(adv_upper) && reg_rdata[4:0] == 5'h01)
        else $error("advert read wrong");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside answer");
    rd_lpa_a: assert property (reg_rd && reg_addr == 5'h05 |=> reg_rdata[15:9] ==
        {$past(partner_next_page), $past(partner_ack), $past(partner_remote_fault),
        2'b00, $past(partner_pause), $past(partner_t4)})
        else $error("partner read wrong");
    copy_hi_a: assert property (three_same |=> ##1
        {partner_next_page, partner_ack, partner_remote_fault} == $past(rx_word[15:13], 2))
        else $error("partner upper flags wrong");
    copy_lo_a: assert property (three_same |=> ##1
        {partner_pause, partner_t4, partner_tx_full, partner_tx_half, partner_10_full,
        partner_10_half} == $past(rx_word[10:5], 2))
        else $error("partner abilities wrong");
    restart_clr_a: assert property (an_restart && !rx_word_valid && !$past(rx_word_valid) |=>
        !partner_t4 && !partner_tx_full && !partner_tx_half &&
        !partner_10_full && !partner_10_half)
        else $error("restart left abilities set");
    load_pulse_a: assert property (partner_loaded |=> !partner_loaded)
        else $error("load notice longer than one cycle");
endmodule // ability_regs_chk
bind autoneg_ability_registers ability_regs_chk i_ability_regs_chk (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adv_upper, .an_restart, .rx_word,
    .rx_word_valid, .tx_word, .partner_next_page, .partner_ack, .partner_remote_fault,
    .partner_pause, .partner_t4, .partner_tx_full, .partner_tx_half, .partner_10_full,
    .partner_10_half, .partner_loaded);

// file: tb/link_partner.sv
// remote link partner sending base link code words
`timescale 1ns/1ps
module link_partner (
    // clock
    input wire clk,
    // words toward the block
    output logic [15:0] rx_word,
    output logic rx_word_valid
);
    initial begin
        rx_word = 16'h0000;
        rx_word_valid = 1'b0;
    end
    // send a word n times with gap idle cycles between copies
    task automatic send(input logic [15:0] w, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            rx_word <= w;
            rx_word_valid <= 1'b1;
            @(posedge clk);
            if (gap > 0 || i == n - 1) begin
                rx_word <= ~w; // idle line shows no stale word
                rx_word_valid <= 1'b0;
                repeat (gap + (i == n - 1)) @(posedge clk);
            end
        end
    endtask
endmodule // link_partner

// file: tb/tb_top.sv
// self-checking bench for the ability registers
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic an_restart = 1'b0;
    logic [15:0] adv = 16'h52e1;
    wire [15:0] reg_rdata, tx_word, rx_word;
    wire rx_word_valid;
    wire pl;
    wire [8:0] pv;
    int miscompares = 0;
    int n_checks = 0;
    // address, write data, expected read back
    logic [36:0] rows [6] = '{
        {5'h04, 16'hffff, 16'h52e1}, {5'h04, 16'h0000, 16'h5281},
        {5'h04, 16'h0040, 16'h52c1}, {5'h04, 16'hffbf, 16'h52a1},
        {5'h05, 16'hffff, 16'h0000}, {5'h1f, 16'hffff, 16'h0000}};
    always #2 clk = ~clk;
    link_partner i_link_partner (.clk(clk), .rx_word(rx_word), .rx_word_valid(rx_word_valid));
    autoneg_ability_registers i_autoneg_ability_registers (.clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adv_upper(9'h0a5), .an_restart(an_restart), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .tx_word(tx_word), .partner_next_page(pv[8]),
        .partner_ack(pv[7]), .partner_remote_fault(pv[6]), .partner_pause(pv[5]),
        .partner_t4(pv[4]), .partner_tx_full(pv[3]), .partner_tx_half(pv[2]),
        .partner_10_full(pv[1]), .partner_10_half(pv[0]), .partner_loaded(pl));
    // compare a value with its expectation
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read, answer compared in the next cycle
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask
    // partner flags expected from a received word
    function automatic logic [15:0] pbits(input logic [15:0] w);
        return {7'h00, w[15:13], w[10:5]};
    endfunction
    // verdict and end of run
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        chk("tx_word", 16'h0061, tx_word);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(5'h04, 16'h52e1);
        rd(5'h05, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i][36:32], rows[i][31:16]);
            rd(rows[i][36:32], rows[i][15:0]);
            if (rows[i][36:32] == 5'h04) adv = rows[i][15:0];
            chk("tx_word", adv, tx_word);
        end
        i_link_partner.send(16'hfde0, 3, 2);
        rd(5'h05, 16'he5e0);
        chk("partner", pbits(16'hfde0), {7'h00, pv});
        wr(5'h05, 16'h0000);
        rd(5'h05, 16'he5e0);
        i_link_partner.send(16'h2020, 2, 0);
        i_link_partner.send(16'h4621, 2, 0);
        rd(5'h05, 16'he5e0);
        i_link_partner.send(16'h4621, 1, 0);
        rd(5'h05, 16'h4621);
        an_restart <= 1'b1;
        @(posedge clk);
        an_restart <= 1'b0;
        rd(5'h05, 16'h0000);
        i_link_partner.send(16'hfde0, 3, 0);
        #1 chk("partner", pbits(16'hfde0), {7'h00, pv});
        chk("partner_loaded", 16'h0001, {15'h0000, pl});
        wr(5'h04, 16'h0000);
        chk("partner_loaded", 16'h0000, {15'h0000, pl});
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(5'h04, 16'h52e1);
        chk("partner", 16'h0000, {7'h00, pv});
        report_and_stop();
    end
    // cut a hang short well beyond the expected run
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule // tb_top
